/* hdl/jcb_bridge.sv */
`timescale 1ns/100ps
module jcb_bridge #(
    parameter int TX_DEPTH = jcb_pkg::DEPTH_DEFAULT,
    parameter int RX_DEPTH = jcb_pkg::DEPTH_DEFAULT,
    parameter int TX_THRESH = jcb_pkg::THRESH_DEFAULT,
    parameter int RX_THRESH = jcb_pkg::THRESH_DEFAULT,
    parameter bit TX_USE_REGS = 1'b0,
    parameter bit RX_USE_REGS = 1'b0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    // register slave port
    input wire logic [jcb_pkg::ADDR_W-1:0] bus_addr_i,
    input wire logic bus_read_i,
    input wire logic bus_write_i,
    input wire logic [jcb_pkg::BUS_W-1:0] bus_wdata_i,
    output logic [jcb_pkg::BUS_W-1:0] bus_rdata_o,
    output logic bus_rvalid_o,
    output logic irq_o,
    // scan hub node port
    input wire logic tck_i,
    input wire logic node_sel_i,
    output logic [jcb_pkg::CHAR_W-1:0] scan_tx_data_o,
    output logic scan_tx_valid_o,
    input wire logic scan_tx_take_i,
    input wire logic [jcb_pkg::CHAR_W-1:0] scan_rx_data_i,
    input wire logic scan_rx_valid_i,
    output logic scan_rx_ready_o
);
    import jcb_pkg::*;

    localparam int TAW = $clog2(TX_DEPTH);
    localparam int RAW = $clog2(RX_DEPTH);

    function automatic bit depth_ok(input int d);
        return (d >= DEPTH_MIN) && (d <= DEPTH_MAX) && ((d & (d - 1)) == 0);
    endfunction : depth_ok

    generate
        if (!depth_ok(TX_DEPTH)) begin : g_bad_tx
            $error("tx depth must be a power of two from 8 to 32768");
        end
        if (!depth_ok(RX_DEPTH)) begin : g_bad_rx
            $error("rx depth must be a power of two from 8 to 32768");
        end
    endgenerate

    // ---------------- system clock domain ----------------
    logic tx_in_ready, tx_out_valid, tx_out_ready;
    logic [CHAR_W-1:0] tx_out_data;
    logic [TAW:0] tx_count;
    logic rx_in_valid, rx_in_ready, rx_out_valid;
    logic [CHAR_W-1:0] rx_in_data, rx_out_data;
    logic [RAW:0] rx_count;
    logic [RAW:0] rx_space;
    logic [TAW:0] tx_space;
    logic sel_data, sel_ctrl;
    logic tx_push, rx_pop;
    logic rx_ie, tx_ie, ovf;
    logic rx_ip, tx_ip;
    logic node_seen;

    assign sel_data = (bus_addr_i == DATA_OFS);
    assign sel_ctrl = (bus_addr_i == CTRL_OFS);
    assign tx_push = bus_write_i && sel_data && tx_in_ready;
    assign rx_pop = bus_read_i && sel_data && rx_out_valid;
    assign rx_space = (RAW+1)'(RX_DEPTH) - rx_count;
    assign tx_space = (TAW+1)'(TX_DEPTH) - tx_count;
    assign rx_ip = (rx_space <= (RAW+1)'(RX_THRESH)) && rx_out_valid;
    assign tx_ip = (tx_count <= (TAW+1)'(TX_THRESH));

    jcb_fifo #(.WIDTH(CHAR_W), .DEPTH(TX_DEPTH), .USE_REGS(TX_USE_REGS)) u_tx_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(tx_push),
        .in_data_i(bus_wdata_i[CHAR_W-1:0]),
        .in_ready_o(tx_in_ready),
        .out_valid_o(tx_out_valid),
        .out_data_o(tx_out_data),
        .out_ready_i(tx_out_ready),
        .count_o(tx_count)
    );

    jcb_fifo #(.WIDTH(CHAR_W), .DEPTH(RX_DEPTH), .USE_REGS(RX_USE_REGS)) u_rx_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(rx_in_valid),
        .in_data_i(rx_in_data),
        .in_ready_o(rx_in_ready),
        .out_valid_o(rx_out_valid),
        .out_data_o(rx_out_data),
        .out_ready_i(rx_pop),
        .count_o(rx_count)
    );

    // control register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rx_ie <= CTRL_IE_RESET;
            tx_ie <= CTRL_IE_RESET;
        end else if (bus_write_i && sel_ctrl) begin
            rx_ie <= bus_wdata_i[CTRL_RX_IE_BIT];
            tx_ie <= bus_wdata_i[CTRL_TX_IE_BIT];
        end
    end

    // sticky: tx write dropped while full; a new drop beats the clear
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ovf <= 1'b0;
        end else if (bus_write_i && sel_data && !tx_in_ready) begin
            ovf <= 1'b1;
        end else if (bus_write_i && sel_ctrl && bus_wdata_i[CTRL_OVF_BIT]) begin
            ovf <= 1'b0;
        end
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus_rdata_o <= '0;
            bus_rvalid_o <= 1'b0;
        end else begin
            bus_rvalid_o <= bus_read_i;
            bus_rdata_o <= '0;
            if (bus_read_i && sel_data) begin
                bus_rdata_o[CHAR_W-1:0] <= rx_pop ? rx_out_data : '0;
                bus_rdata_o[DATA_RVALID_BIT] <= rx_pop;
                bus_rdata_o[BUS_W-1:DATA_RAVAIL_LSB] <= 16'(rx_pop ? rx_count - 1'b1 : rx_count);
            end else if (bus_read_i && sel_ctrl) begin
                bus_rdata_o[CTRL_RX_IE_BIT] <= rx_ie;
                bus_rdata_o[CTRL_TX_IE_BIT] <= tx_ie;
                bus_rdata_o[CTRL_RX_IP_BIT] <= rx_ip;
                bus_rdata_o[CTRL_TX_IP_BIT] <= tx_ip;
                bus_rdata_o[CTRL_OVF_BIT] <= ovf;
                bus_rdata_o[CTRL_NODE_BIT] <= node_seen;
                bus_rdata_o[BUS_W-1:CTRL_WSPACE_LSB] <= 16'(tx_space);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (rx_ie && rx_ip) || (tx_ie && tx_ip);
        end
    end

    // ---------------- scan clock domain ----------------
    logic [SYNC_STAGES-1:0] trst_s;
    logic trst;
    logic tx_c_valid, tx_c_ready;
    logic [CHAR_W-1:0] tx_c_data;
    logic rx_hold_full, rx_c_ready;
    logic [CHAR_W-1:0] rx_hold;
    logic rx_take, rx_drain, next_rx_hold_full;
    logic t_sel_seen;
    logic [SYNC_STAGES-1:0] sel_s;

    // reset carried into the scan domain; takes effect after second and third agree
    always_ff @(posedge tck_i) begin
        trst_s <= {trst_s[SYNC_STAGES-2:0], rst_i};
        if (trst_s[1] == trst_s[2]) trst <= trst_s[2];
    end

    jcb_cdc_fifo #(.WIDTH(CHAR_W), .DEPTH(CDC_DEPTH)) u_tx_cdc (
        .wclk_i(mclk_i),
        .wrst_i(rst_i),
        .w_valid_i(tx_out_valid),
        .w_data_i(tx_out_data),
        .w_ready_o(tx_out_ready),
        .rclk_i(tck_i),
        .rrst_i(trst),
        .r_valid_o(tx_c_valid),
        .r_data_o(tx_c_data),
        .r_ready_i(tx_c_ready)
    );

    // tx output stage refills when empty or when the hub takes it
    assign tx_c_ready = !scan_tx_valid_o || (node_sel_i && scan_tx_take_i);

    always_ff @(posedge tck_i) begin
        if (trst) begin
            scan_tx_valid_o <= 1'b0;
            scan_tx_data_o <= '0;
        end else if (tx_c_ready) begin
            scan_tx_valid_o <= tx_c_valid;
            scan_tx_data_o <= tx_c_data;
        end
    end

    // rx skid register keeps the hub ready a flop output
    assign rx_take = scan_rx_ready_o && scan_rx_valid_i && node_sel_i;
    assign rx_drain = rx_hold_full && rx_c_ready;
    assign next_rx_hold_full = rx_take || (rx_hold_full && !rx_drain);

    always_ff @(posedge tck_i) begin
        if (trst) begin
            rx_hold_full <= 1'b0;
            rx_hold <= '0;
            scan_rx_ready_o <= 1'b0;
        end else begin
            rx_hold_full <= next_rx_hold_full;
            if (rx_take) rx_hold <= scan_rx_data_i;
            scan_rx_ready_o <= !next_rx_hold_full;
        end
    end

    jcb_cdc_fifo #(.WIDTH(CHAR_W), .DEPTH(CDC_DEPTH)) u_rx_cdc (
        .wclk_i(tck_i),
        .wrst_i(trst),
        .w_valid_i(rx_hold_full),
        .w_data_i(rx_hold),
        .w_ready_o(rx_c_ready),
        .rclk_i(mclk_i),
        .rrst_i(rst_i),
        .r_valid_o(rx_in_valid),
        .r_data_o(rx_in_data),
        .r_ready_i(rx_in_ready)
    );

    // hub has selected this node at least once since reset
    always_ff @(posedge tck_i) begin
        if (trst) t_sel_seen <= 1'b0;
        else if (node_sel_i) t_sel_seen <= 1'b1;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sel_s <= '0;
            node_seen <= 1'b0;
        end else begin
            sel_s <= {sel_s[SYNC_STAGES-2:0], t_sel_seen};
            if (sel_s[1] == sel_s[2]) node_seen <= sel_s[2];
        end
    end
endmodule : jcb_bridge

/* common/jcb_pkg.sv */
package jcb_pkg;
    localparam int CHAR_W = 8;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] DATA_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 3'h4;
    // data register fields
    localparam int DATA_RVALID_BIT = 15;
    localparam int DATA_RAVAIL_LSB = 16;
    // control register fields
    localparam int CTRL_RX_IE_BIT = 0;
    localparam int CTRL_TX_IE_BIT = 1;
    localparam int CTRL_RX_IP_BIT = 8;
    localparam int CTRL_TX_IP_BIT = 9;
    localparam int CTRL_OVF_BIT = 10;
    localparam int CTRL_NODE_BIT = 11;
    localparam int CTRL_WSPACE_LSB = 16;
    localparam logic CTRL_IE_RESET = 1'b0;
    localparam int DEPTH_MIN = 8;
    localparam int DEPTH_MAX = 32768;
    localparam int DEPTH_DEFAULT = 32;
    localparam int THRESH_DEFAULT = 8;
    localparam int CDC_DEPTH = 8;
    localparam int SYNC_STAGES = 3;
endpackage : jcb_pkg

/* hdl/jcb_fifo.sv */
`timescale 1ns/100ps
module jcb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter bit USE_REGS = 1'b0,
    localparam int AW = $clog2(DEPTH)
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [AW:0] count_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];
    assign count_o = count;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // flop storage clears on reset, block storage does not; both read the same
    generate
        if (USE_REGS) begin : g_regs
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
                end else if (push) begin
                    mem[wr_ptr] <= in_data_i;
                end
            end
        end else begin : g_ram
            always_ff @(posedge mclk_i) begin
                if (push) mem[wr_ptr] <= in_data_i;
            end
        end
    endgenerate
endmodule : jcb_fifo

/* hdl/jcb_cdc_fifo.sv */
`timescale 1ns/100ps
module jcb_cdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    localparam int AW = $clog2(DEPTH)
) (
    input wire logic wclk_i,
    input wire logic wrst_i,
    input wire logic w_valid_i,
    input wire logic [WIDTH-1:0] w_data_i,
    output logic w_ready_o,
    input wire logic rclk_i,
    input wire logic rrst_i,
    output logic r_valid_o,
    output logic [WIDTH-1:0] r_data_o,
    input wire logic r_ready_i
);
    import jcb_pkg::*;

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin, wgray, rbin, rgray;
    logic [AW:0] rgray_s [SYNC_STAGES];
    logic [AW:0] wgray_s [SYNC_STAGES];
    logic [AW:0] rgray_w, wgray_r;
    logic push, pop;

    assign w_ready_o = (wgray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
    assign r_valid_o = (rgray != wgray_r);
    assign push = w_valid_i && w_ready_o;
    assign pop = r_valid_o && r_ready_i;
    assign r_data_o = mem[rbin[AW-1:0]];

    // write side
    always_ff @(posedge wclk_i) begin
        if (wrst_i) begin
            wbin <= '0;
            wgray <= '0;
        end else if (push) begin
            wbin <= wbin + 1'b1;
            wgray <= bin2gray(wbin + 1'b1);
        end
    end

    always_ff @(posedge wclk_i) begin
        if (push) mem[wbin[AW-1:0]] <= w_data_i;
    end

    // read pointer into write domain, taken once last two stages agree
    always_ff @(posedge wclk_i) begin
        if (wrst_i) begin
            for (int i = 0; i < SYNC_STAGES; i++) rgray_s[i] <= '0;
            rgray_w <= '0;
        end else begin
            rgray_s[0] <= rgray;
            for (int i = 1; i < SYNC_STAGES; i++) rgray_s[i] <= rgray_s[i-1];
            if (rgray_s[1] == rgray_s[2]) rgray_w <= rgray_s[2];
        end
    end

    // read side
    always_ff @(posedge rclk_i) begin
        if (rrst_i) begin
            rbin <= '0;
            rgray <= '0;
        end else if (pop) begin
            rbin <= rbin + 1'b1;
            rgray <= bin2gray(rbin + 1'b1);
        end
    end

    always_ff @(posedge rclk_i) begin
        if (rrst_i) begin
            for (int i = 0; i < SYNC_STAGES; i++) wgray_s[i] <= '0;
            wgray_r <= '0;
        end else begin
            wgray_s[0] <= wgray;
            for (int i = 1; i < SYNC_STAGES; i++) wgray_s[i] <= wgray_s[i-1];
            if (wgray_s[1] == wgray_s[2]) wgray_r <= wgray_s[2];
        end
    end
endmodule : jcb_cdc_fifo

/* bench/jcb_bridge_assertions.sv */
`timescale 1ns/100ps
module jcb_bridge_assertions #(
    parameter int TX_DEPTH = 32,
    parameter int RX_DEPTH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [jcb_pkg::ADDR_W-1:0] bus_addr_i,
    input wire logic bus_read_i,
    input wire logic bus_write_i,
    input wire logic [jcb_pkg::BUS_W-1:0] bus_wdata_i,
    input wire logic [jcb_pkg::BUS_W-1:0] bus_rdata_o,
    input wire logic bus_rvalid_o,
    input wire logic irq_o
);
    import jcb_pkg::*;
    logic [1:0] ie;
    logic rd_data;
    logic rd_ctrl;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    assign rd_data = bus_read_i && bus_addr_i == DATA_OFS;
    assign rd_ctrl = bus_read_i && bus_addr_i == CTRL_OFS;
    // interrupt enables as last written
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ie <= 2'h0;
        end else if (bus_write_i && bus_addr_i == CTRL_OFS) begin
            ie <= bus_wdata_i[1:0];
        end
    end
    property p_answer; bus_read_i |=> bus_rvalid_o; endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_quiet; !bus_read_i |=> !bus_rvalid_o && bus_rdata_o == '0; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without read");
    property p_unmap; bus_read_i && !rd_data && !rd_ctrl |=> bus_rdata_o == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_empty; rd_data |=> bus_rdata_o[DATA_RVALID_BIT] || bus_rdata_o[7:0] == 8'h00; endproperty
    a_empty: assert property (p_empty) else $error("char without valid");
    property p_avail; rd_data |=> bus_rdata_o[31:16] <= RX_DEPTH; endproperty
    a_avail: assert property (p_avail) else $error("rx count above depth");
    property p_space; rd_ctrl |=> bus_rdata_o[31:16] <= TX_DEPTH; endproperty
    a_space: assert property (p_space) else $error("tx space above depth");
    property p_irq_rst; $fell(rst_i) |-> !irq_o; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
    property p_irq_off; (ie == 2'h0) [*2] |-> !irq_o; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_tx_full; rd_ctrl && ie == 2'h2 ##1 bus_rdata_o[31:16] == 16'h0000 |-> !irq_o; endproperty
    a_tx_full: assert property (p_tx_full) else $error("irq with tx full");
    c_irq: cover property ($rose(irq_o));
    c_full: cover property (rd_ctrl ##1 bus_rdata_o[31:16] == 16'h0000);
    c_char: cover property (rd_data ##1 bus_rdata_o[DATA_RVALID_BIT]);
endmodule : jcb_bridge_assertions

bind jcb_bridge jcb_bridge_assertions #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) u_chk (
    .mclk_i, .rst_i, .bus_addr_i, .bus_read_i, .bus_write_i, .bus_wdata_i, .bus_rdata_o,
    .bus_rvalid_o, .irq_o
);

/* bench/jcb_host_model.sv */
`timescale 1ns/100ps
module jcb_host_model (
    input wire logic tck_i,
    input wire logic [1:0] mode_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic rx_ready_i,
    output logic sel_o,
    output logic take_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o
);
    logic [7:0] got_q[$];
    logic [7:0] send_q[$];
    logic [3:0] tick = 4'h9;
    logic go;
    initial begin
        sel_o = 1'b0;
        take_o = 1'b0;
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
    end
    // mode 0 every edge, 1 random stalls, 2 node deselected
    always @(posedge tck_i) begin
        go = mode_i == 2'h0 || (mode_i == 2'h1 && tick[0]);
        tick <= {tick[2:0], tick[3] ^ tick[2]};
        sel_o <= mode_i != 2'h2;
        take_o <= go;
        if (sel_o && take_o && tx_valid_i) begin
            got_q.push_back(tx_data_i);
        end
        if (sel_o && rx_valid_o && rx_ready_i) begin
            send_q.delete(0);
            rx_valid_o <= 1'b0;
            rx_data_o <= ~rx_data_o;
        end else if (!rx_valid_o && send_q.size() > 0 && go) begin
            rx_valid_o <= 1'b1;
            rx_data_o <= send_q[0];
        end
    end
endmodule : jcb_host_model

/* bench/tb_jcb_bridge.sv */
`timescale 1ns/100ps
module tb_jcb_bridge;
    import jcb_pkg::*;
    localparam int DEPTH = DEPTH_DEFAULT;
    localparam logic [31:0] CMASK = 32'hffff_f4ff;
    logic mclk = 1'b0;
    logic tck = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [BUS_W-1:0] wdata = '0;
    logic [BUS_W-1:0] rdata;
    logic [BUS_W-1:0] got;
    logic rvalid, irq, sel, take, txv, rxv, rxr;
    logic [CHAR_W-1:0] txd, rxd;
    logic [1:0] mode = 2'h2;
    logic [7:0] seed = 8'h18;
    logic [7:0] sent[$];
    int fail_count = 0;
    int tests_run = 0;
    always #5 mclk = ~mclk;
    always #6 tck = ~tck;
    // tx storage in flops, rx in memory
    jcb_bridge #(.TX_USE_REGS(1'b1)) dut (
        .mclk_i(mclk), .rst_i(rst), .bus_addr_i(addr), .bus_read_i(rd), .bus_write_i(wr),
        .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .irq_o(irq), .tck_i(tck),
        .node_sel_i(sel), .scan_tx_data_o(txd), .scan_tx_valid_o(txv), .scan_tx_take_i(take),
        .scan_rx_data_i(rxd), .scan_rx_valid_i(rxv), .scan_rx_ready_o(rxr)
    );
    jcb_host_model hub (
        .tck_i(tck), .mode_i(mode), .tx_data_i(txd), .tx_valid_i(txv), .rx_ready_i(rxr),
        .sel_o(sel), .take_o(take), .rx_data_o(rxd), .rx_valid_o(rxv)
    );
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function automatic logic [31:0] ctrl_exp(input int space, input logic ovf, input logic [1:0] ie);
        return {space[15:0], 5'h00, ovf, 8'h00, ie};
    endfunction : ctrl_exp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    // the bench is the only master on this bridge's bus
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [ADDR_W-1:0] a);
        @(negedge mclk);
        addr = a;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        got = rdata;
        check(rvalid, 1'b1);
    endtask : rd_reg
    // kind 0 waits for the request, kind 1 for n chars at the host
    task automatic wait_until(input int kind, input int n);
        for (int i = 0; i < 3000; i++) begin
            if ((kind == 0 && irq === 1'b1) || (kind == 1 && hub.got_q.size() >= n)) begin
                return;
            end
            @(negedge mclk);
        end
        fail_count++;
        $display("unexpected at %0t: wait ran out", $time);
        summarize();
    endtask : wait_until
    task automatic do_reset;
        rst = 1'b1;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (12) @(negedge mclk);
        check(irq, 1'b0);
        rd_reg(CTRL_OFS);
        check(got & CMASK, ctrl_exp(DEPTH, 1'b0, 2'h0));
        check(got[CTRL_NODE_BIT:CTRL_RX_IP_BIT], 4'h2);
        rd_reg(DATA_OFS);
        check(got, 32'h0000_0000);
    endtask : do_reset
    task automatic send_chars(input int n);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            sent.push_back(seed);
            wr_reg(DATA_OFS, {24'h00_0000, seed});
        end
    endtask : send_chars
    initial begin
        do_reset();
        rd_reg(3'h2);
        check(got, 32'h0000_0000);
        mode = 2'h0;
        wr_reg(CTRL_OFS, 32'h0000_0002);
        send_chars(20);
        wait_until(1, 20);
        check(irq, 1'b1);
        // host stalls: fill the tx side until writes are dropped
        mode = 2'h2;
        repeat (20) @(negedge mclk);
        send_chars(50);
        rd_reg(CTRL_OFS);
        check(got & CMASK, ctrl_exp(0, 1'b1, 2'h2));
        check(got[CTRL_NODE_BIT:CTRL_RX_IP_BIT], 4'hc);
        check(irq, 1'b0);
        wr_reg(CTRL_OFS, 32'h0000_0402);
        rd_reg(CTRL_OFS);
        check(got[CTRL_OVF_BIT], 1'b0);
        mode = 2'h1;
        wait_until(1, 20 + DEPTH);
        repeat (2000) @(negedge mclk);
        check(irq, 1'b1);
        for (int i = 0; i < hub.got_q.size(); i++) begin
            check(hub.got_q[i], sent[i]);
        end
        // tx fifo, crossing fifo and output stage held the stalled burst
        check(hub.got_q.size(), 20 + DEPTH + CDC_DEPTH + 1);
        // host to bus direction with random host stalls
        wr_reg(CTRL_OFS, 32'h0000_0001);
        repeat (2) @(negedge mclk);
        check(irq, 1'b0);
        sent.delete();
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            sent.push_back(seed);
            hub.send_q.push_back(seed);
        end
        wait_until(0, 0);
        repeat (300) @(negedge mclk);
        check(irq, 1'b1);
        for (int i = 0; i < 40; i++) begin
            rd_reg(DATA_OFS);
            check(got[15:0], {8'h80, sent[i]});
        end
        rd_reg(DATA_OFS);
        check(got, 32'h0000_0000);
        repeat (2) @(negedge mclk);
        check(irq, 1'b0);
        mode = 2'h2;
        send_chars(5);
        do_reset();
        summarize();
    end
endmodule : tb_jcb_bridge
